// ### hdl/flash_program_erase_control.sv
// program, erase and margin control with block protection for the second flash array
`timescale 1ns/1ps
module flash_program_erase_control
   import flash_ctrl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [7:0] bus_rdata,
   input wire logic [7:0] range_lock_byte,
   input wire logic [7:0] array_rdata,
   input wire logic override_high_voltage,
   input wire logic wait_mode,
   input wire logic stop_mode,
   output logic program_select,
   output logic erase_select,
   output logic high_voltage_on,
   output logic margin_read,
   output logic [1:0] erase_size,
   output logic [15:0] target_addr,
   output logic pump_on,
   output logic pump_tick,
   output logic array_standby
);

   // whole state of the controller
   typedef struct packed
   {
      logic [1:0] pump_divider;    // pump clock factor
      logic [1:0] erase_size;      // erase block size
      logic high_voltage_on;       // charge pump drives array
      logic margin_read;           // margin read selected
      logic erase_select;          // erase mode
      logic program_select;        // program mode
      logic [7:0] lock_latch;      // lock byte caught on read
      logic lock_read_seen;        // lock byte read during this mode
      logic addr_latched;          // target address caught
      logic [15:0] target_addr;    // first array write address
      logic [2:0] hv_sync;         // pin synchroniser
      logic hv_override;           // filtered high-voltage detect
      logic pump_on;               // pump running
      logic standby;               // array in low-power standby
      logic [7:0] rdata;           // read data back to the cpu
   } ctrl_state_s;

   ctrl_state_s state;
   ctrl_state_s next_state;

   logic in_window;       // address falls in user memory
   logic mode_active;     // program or erase selected
   logic [15:0] lock_start; // lowest locked address
   logic any_lock;        // some lock bit is set
   logic [15:0] target_end; // top of the latched target range
   logic protect_hit;     // target overlaps locked range
   logic seq_ready;       // sequence allows high voltage
   logic req_pgm;         // write asks for program
   logic req_erase;       // write asks for erase
   logic new_mode;        // mode after this cycle's write

   // user memory window decode
   always_comb
   begin
      in_window = ((bus_addr >= WIN0_LO) && (bus_addr <= WIN0_HI))
         || ((bus_addr >= WIN1_LO) && (bus_addr <= WIN1_HI))
         || ((bus_addr >= WIN2_LO) && (bus_addr <= WIN2_HI)); // R13
   end

   // locked range from the latched byte; the lowest start governs
   always_comb
   begin
      any_lock = |state.lock_latch[BIT_LOCK_QUARTER:BIT_LOCK_WHOLE]; // R02
      if (state.lock_latch[BIT_LOCK_WHOLE])
      begin
         lock_start = LOCK_START_0; // R01 R03
      end
      else if (state.lock_latch[BIT_LOCK_LOWER])
      begin
         lock_start = LOCK_START_1; // R01 R03
      end
      else if (state.lock_latch[BIT_LOCK_HALF])
      begin
         lock_start = LOCK_START_2; // R01 R03
      end
      else
      begin
         lock_start = LOCK_START_3; // R01
      end
   end

   // top of the target range: a page for program, the block for erase
   always_comb
   begin
      if (state.program_select)
      begin
         target_end = state.target_addr | MASK_PAGE; // R12
      end
      else
      begin
         unique case (erase_size_e'(state.erase_size))
            ERASE_FULL: target_end = ARRAY_TOP; // R17
            ERASE_HALF: target_end = state.target_addr | MASK_HALF; // R17 R23
            ERASE_EIGHT_ROWS: target_end = state.target_addr | MASK_EIGHT_ROWS; // R17 R23
            ERASE_ROW: target_end = state.target_addr | MASK_ROW; // R12 R23
         endcase
      end
   end

   // locks run to the array top, so any target ending at or above the start overlaps
   always_comb
   begin
      mode_active = state.program_select | state.erase_select;
      protect_hit = mode_active && state.lock_read_seen && state.addr_latched
         && any_lock && !state.hv_override && (target_end >= lock_start); // R04 R22 R26
      seq_ready = state.lock_read_seen && state.addr_latched && !protect_hit; // R18 R21
   end

   // next state
   always_comb
   begin
      next_state = state;
      req_pgm = bus_wdata[BIT_PGM];
      req_erase = bus_wdata[BIT_ERASE];
      new_mode = mode_active;

      // three-stage pin synchroniser, change taken when stages two and three agree
      next_state.hv_sync = {state.hv_sync[1:0], override_high_voltage};
      if (state.hv_sync[1] == state.hv_sync[2])
      begin
         next_state.hv_override = state.hv_sync[2];
      end

      // control register write
      if (bus_write && (bus_addr == CTRL_ADDR))
      begin
         next_state.pump_divider = bus_wdata[BIT_DIV_HI:BIT_DIV_LO]; // R16
         next_state.erase_size = bus_wdata[BIT_BLK_HI:BIT_BLK_LO]; // R17
         if (!(req_pgm && req_erase))
         begin
            // a write asking for both keeps the old pair
            next_state.program_select = req_pgm; // R20
            next_state.erase_select = req_erase; // R20
         end
         new_mode = next_state.program_select | next_state.erase_select;
         // high voltage only with a mode and a completed sequence
         next_state.high_voltage_on = bus_wdata[BIT_HV] && new_mode && seq_ready; // R18
         // margin refused while high voltage is on
         next_state.margin_read = bus_wdata[BIT_MARGIN] && !state.high_voltage_on; // R19
         if (!new_mode)
         begin
            // leaving the mode disarms the sequence
            next_state.lock_read_seen = 1'b0;
            next_state.addr_latched = 1'b0;
         end
      end

      // reading the lock byte latches it and, in program or erase mode, arms the sequence
      if (bus_read && (bus_addr == LOCK_ADDR))
      begin
         next_state.lock_latch = range_lock_byte; // R21
         if (mode_active)
         begin
            next_state.lock_read_seen = 1'b1; // R21
         end
      end

      // first array write in a mode catches the target address
      if (bus_write && in_window && mode_active && !state.addr_latched)
      begin
         next_state.target_addr = bus_addr; // R23
         next_state.addr_latched = 1'b1;
      end

      // protected target drops the mode, which keeps high voltage off
      if (protect_hit)
      begin
         next_state.program_select = 1'b0; // R22
         next_state.erase_select = 1'b0; // R22
         next_state.high_voltage_on = 1'b0; // R22
         next_state.lock_read_seen = 1'b0;
         next_state.addr_latched = 1'b0;
      end

      // wait and stop cut the pump but leave the mode bits alone
      next_state.pump_on = next_state.high_voltage_on && !wait_mode && !stop_mode; // R06 R07
      // stop while in read mode puts the array in standby
      next_state.standby = stop_mode && !next_state.program_select && !next_state.erase_select; // R08

      // read data: control register, lock byte or array
      next_state.rdata = IDLE_READ;
      if (bus_read)
      begin
         if (bus_addr == CTRL_ADDR)
         begin
            next_state.rdata = {state.pump_divider, state.erase_size, state.high_voltage_on,
               state.margin_read, state.erase_select, state.program_select};
         end
         else if (bus_addr == LOCK_ADDR)
         begin
            next_state.rdata = range_lock_byte;
         end
         else if (in_window)
         begin
            next_state.rdata = array_rdata; // R11
         end
      end
   end

   // state register; every control bit clears on reset
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= '0; // R25
      end
      else
      begin
         state <= next_state;
      end
   end

   // pump clock ticks only while the pump runs
   pump_clock_divider u_pump_div
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(state.pump_on),
      .div_code(pump_div_e'(state.pump_divider)),
      .pump_tick(pump_tick)
   );

   // outputs straight from the state register
   assign bus_rdata = state.rdata;
   assign program_select = state.program_select;
   assign erase_select = state.erase_select;
   assign high_voltage_on = state.high_voltage_on;
   assign margin_read = state.margin_read;
   assign erase_size = state.erase_size;
   assign target_addr = state.target_addr;
   assign pump_on = state.pump_on;
   assign array_standby = state.standby;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // write to the control register in a given cycle
   sequence ctrl_write_s;
      bus_write && bus_addr == CTRL_ADDR;
   endsequence

   // lock byte read while in a mode
   sequence lock_read_s;
      bus_read && bus_addr == LOCK_ADDR && (program_select || erase_select);
   endsequence

   mode_exclusive_a: assert property (!(program_select && erase_select)) // R20
      else $error("program and erase both set");
   hv_needs_mode_a: assert property (high_voltage_on |-> (program_select || erase_select)) // R18
      else $error("high voltage on without a mode");
   hv_no_seq_a: assert property ((ctrl_write_s and (!state.lock_read_seen)) |=> !$rose(high_voltage_on)) // R18 R21
      else $error("high voltage set before lock byte read");
   margin_refused_a: assert property ((ctrl_write_s and high_voltage_on) |=> !margin_read) // R19
      else $error("margin set while high voltage on");
   lock_latch_a: assert property (lock_read_s |=> (state.lock_latch == $past(range_lock_byte) && state.lock_read_seen)) // R21
      else $error("lock byte not latched on read");
   protect_clear_a: assert property (protect_hit |=> (!program_select && !erase_select && !high_voltage_on)) // R22
      else $error("protected target kept its mode");
   pump_wait_a: assert property ((wait_mode || stop_mode) |=> !pump_on) // R06 R07
      else $error("pump running in wait or stop");
   mode_kept_a: assert property ((stop_mode && program_select && !bus_write && !protect_hit) |=> program_select) // R07
      else $error("stop dropped the program mode");
   standby_a: assert property ((stop_mode && !program_select && !erase_select && !bus_write) |=> array_standby) // R08
      else $error("stop in read mode without standby");
   // with the override present nothing but a control write may drop the mode
   override_a: assert property ((state.hv_override && program_select && !bus_write) |=> program_select) // R04
      else $error("protection active during high-voltage override");
   erase_latch_a: assert property ((bus_write && in_window && erase_select && !state.addr_latched)
      |=> target_addr == $past(bus_addr)) // R23
      else $error("erase target address not latched");

endmodule : flash_program_erase_control

// ### hdl/pump_clock_divider.sv
// charge pump clock tick generator dividing the bus clock
`timescale 1ns/1ps
module pump_clock_divider
   import flash_ctrl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   input wire pump_div_e div_code,
   output logic pump_tick
);

   // whole state of the divider
   typedef struct packed
   {
      logic [1:0] count;
      logic tick;
   } div_state_s;

   div_state_s state;
   div_state_s next_state;
   logic [1:0] limit;

   // terminal count for the selected factor
   always_comb
   begin
      unique case (div_code)
         DIV_ONE: limit = ONE_LIMIT; // every bus cycle
         DIV_TWO_A, DIV_TWO_B: limit = HALF_LIMIT;
         DIV_FOUR: limit = QUARTER_LIMIT;
      endcase
   end

   // count bus cycles and emit one tick per period
   always_comb
   begin
      next_state = state;
      next_state.tick = 1'b0;
      if (!run)
      begin
         // pump idle: hold counter at zero
         next_state.count = 2'h0;
      end
      else if (state.count >= limit)
      begin
         next_state.count = 2'h0;
         next_state.tick = 1'b1; // R24
      end
      else
      begin
         next_state.count = state.count + 2'h1;
      end
   end

   // state register
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign pump_tick = state.tick;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // divide by four gives no further tick in the three cycles after a tick
   div_four_a: assert property ((run && div_code == DIV_FOUR && pump_tick) ##1 (run && div_code == DIV_FOUR) [*2]
      |-> (!pump_tick && !$past(pump_tick)) ##1 !pump_tick) // R24
      else $error("pump tick too frequent at divide by four");
   // divide by one ticks every cycle
   div_one_a: assert property ((run && div_code == DIV_ONE) [*2] |=> pump_tick) // R24
      else $error("pump tick missing at divide by one");

endmodule : pump_clock_divider

// ### include/flash_ctrl_pkg.sv
// constants, types and field layout shared by the flash program and erase control
//
// Function
// [R01] each lock bit locks start to array top
// [R02] all lock bits zero leaves array open
// [R03] several lock bits: lowest start governs
// [R04] high-voltage detect bypasses all protection
// [R05] software writes lock byte via other array
// [R06] wait mode stops pump, keeps mode bits
// [R07] stop mode stops pump, keeps mode bits
// [R08] stop in read mode enters standby
// [R09] software avoids wait/stop during operations
// [R10] software leaves low power by reset
// [R11] erased bit reads 0, programmed 1
// [R12] eight-byte pages, 64-byte rows, row erase
// [R13] three user windows, control at fe11
// [R14] each page programmed once per erase
// [R15] software uses program plus margin loop
// [R16] divider bits pick pump clock factor
// [R17] block-size bits pick erase block
// [R18] high voltage needs mode and sequence
// [R19] margin refused while high voltage on
// [R20] program and erase never both set
// [R21] lock byte read latches it, arms sequence
// [R22] protected target clears program or erase
// [R23] erase latches cared address from write
// [R24] divide by 1, 2, 2, 4 per code
// [R25] control bits reset to zero
// [R26] latched target checked against latched locks
package flash_ctrl_pkg;

   // bus addresses
   localparam logic [15:0] CTRL_ADDR = 16'hfe11;
   localparam logic [15:0] LOCK_ADDR = 16'hff81;
   // user memory windows
   localparam logic [15:0] WIN0_LO = 16'h0450;
   localparam logic [15:0] WIN0_HI = 16'h04ff;
   localparam logic [15:0] WIN1_LO = 16'h0580;
   localparam logic [15:0] WIN1_HI = 16'h05ff;
   localparam logic [15:0] WIN2_LO = 16'h0e00;
   localparam logic [15:0] WIN2_HI = 16'h7fff;
   // array top and lock start addresses
   localparam logic [15:0] ARRAY_TOP = 16'h7fff;
   localparam logic [15:0] LOCK_START_0 = 16'h0450;
   localparam logic [15:0] LOCK_START_1 = 16'h1000;
   localparam logic [15:0] LOCK_START_2 = 16'h2000;
   localparam logic [15:0] LOCK_START_3 = 16'h4000;
   // low address bits not cared for each target size
   localparam logic [15:0] MASK_HALF = 16'h3fff;
   localparam logic [15:0] MASK_EIGHT_ROWS = 16'h01ff;
   localparam logic [15:0] MASK_ROW = 16'h003f;
   localparam logic [15:0] MASK_PAGE = 16'h0007;
   // control register bit positions
   localparam int BIT_PGM = 0;
   localparam int BIT_ERASE = 1;
   localparam int BIT_MARGIN = 2;
   localparam int BIT_HV = 3;
   localparam int BIT_BLK_LO = 4;
   localparam int BIT_BLK_HI = 5;
   localparam int BIT_DIV_LO = 6;
   localparam int BIT_DIV_HI = 7;
   // lock byte bit positions
   localparam int BIT_LOCK_WHOLE = 0;
   localparam int BIT_LOCK_LOWER = 1;
   localparam int BIT_LOCK_HALF = 2;
   localparam int BIT_LOCK_QUARTER = 3;
   // reset and idle values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] IDLE_READ = 8'h00;
   localparam logic [2:0] SYNC_RESET = 3'h0;
   // pump divider terminal counts
   localparam logic [1:0] ONE_LIMIT = 2'h0;
   localparam logic [1:0] HALF_LIMIT = 2'h1;
   localparam logic [1:0] QUARTER_LIMIT = 2'h3;

   // erase block size codes
   typedef enum logic [1:0]
   {
      ERASE_FULL = 2'b00,
      ERASE_HALF = 2'b01,
      ERASE_EIGHT_ROWS = 2'b10,
      ERASE_ROW = 2'b11
   } erase_size_e;

   // pump divider codes
   typedef enum logic [1:0]
   {
      DIV_ONE = 2'b00,
      DIV_TWO_A = 2'b01,
      DIV_TWO_B = 2'b10,
      DIV_FOUR = 2'b11
   } pump_div_e;

endpackage : flash_ctrl_pkg

// ### testbench/flash_program_erase_control_tb.sv
// self-checking bench for the flash program and erase control block
`timescale 1ns/1ps
module flash_program_erase_control_tb;
   import flash_ctrl_pkg::*;

   logic sys_clk; // bus clock
   logic rst; // async reset, active high
   logic [15:0] bus_addr; // cpu address
   logic [7:0] bus_wdata; // cpu write data
   logic bus_write; // write strobe
   logic bus_read; // read strobe
   logic [7:0] bus_rdata; // read data from the block
   logic [7:0] range_lock_byte; // lock byte held in the sibling array
   logic [7:0] array_rdata; // array read data
   logic override_high_voltage; // high-voltage detect pin
   logic wait_mode; // cpu in wait
   logic stop_mode; // cpu in stop
   logic program_select, erase_select, high_voltage_on, margin_read;
   logic [1:0] erase_size; // erase block size bits
   logic [15:0] target_addr; // latched target address
   logic pump_on, pump_tick, array_standby;
   logic [7:0] exp_q[$]; // expected read data, oldest first
   logic rd_seen; // a read was taken at the previous edge
   int num_errors = 0;
   int n_tests = 0;

   flash_program_erase_control u_dut (.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .range_lock_byte(range_lock_byte),
      .array_rdata(array_rdata), .override_high_voltage(override_high_voltage), .wait_mode(wait_mode),
      .stop_mode(stop_mode), .program_select(program_select), .erase_select(erase_select),
      .high_voltage_on(high_voltage_on), .margin_read(margin_read), .erase_size(erase_size),
      .target_addr(target_addr), .pump_on(pump_on), .pump_tick(pump_tick), .array_standby(array_standby));

   // free-running bus clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // print the counts and the verdict, then stop
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   // compare one value and count it
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // one bus write, strobe high for a single cycle
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge sys_clk);
      bus_write <= 1'b0;
   endtask : wr

   // one bus read; the expected data goes onto the queue
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_read <= 1'b1;
      exp_q.push_back(exp);
      @(posedge sys_clk);
      bus_read <= 1'b0;
   endtask : rd

   // wait a fixed number of cycles
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : idle

   // read data is registered, so compare one edge after the read is taken
   always @(posedge sys_clk)
   begin
      if (rd_seen === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(16'hdead, 16'h0000);
         else
            check({8'h00, bus_rdata}, {8'h00, exp_q.pop_front()});
      end
      rd_seen <= bus_read;
   end

   // protection verdict worked out from the lock byte and the target span
   function automatic logic hit_of(input logic [3:0] lk, input logic [15:0] a, input logic [7:0] c,
      input logic ov);
      logic [15:0] top;
      logic [15:0] start;
      top = a | 16'h0007;
      if (c[1])
         case (c[5:4])
            2'b00: top = 16'h7fff;
            2'b01: top = a | 16'h3fff;
            2'b10: top = a | 16'h01ff;
            default: top = a | 16'h003f;
         endcase
      start = lk[0] ? 16'h0450 : lk[1] ? 16'h1000 : lk[2] ? 16'h2000 : 16'h4000;
      return !ov && (lk != 4'h0) && (top >= start);
   endfunction : hit_of

   // full program or erase sequence: mode, lock read, target write, high voltage
   task automatic op(input logic [3:0] lk, input logic [15:0] a, input logic [7:0] c, input logic ov);
      logic hit;
      int ticks;
      hit = hit_of(lk, a, c, ov);
      ticks = 0;
      @(posedge sys_clk);
      override_high_voltage <= ov;
      range_lock_byte <= {4'($urandom_range(15, 0)), lk};
      idle(6);
      wr(CTRL_ADDR, c);
      rd(LOCK_ADDR, range_lock_byte);
      wr(a, 8'($urandom));
      idle(3);
      check(target_addr, a);
      rd(CTRL_ADDR, hit ? (c & 8'hfc) : c);
      if (!hit)
      begin
         wr(CTRL_ADDR, c | 8'h08);
         rd(CTRL_ADDR, c | 8'h08);
         check({15'h0, pump_on}, 16'h0001);
         repeat (16) @(posedge sys_clk) if (pump_tick === 1'b1) ticks++;
         check(ticks, 16 >> ((c[7:6] == 2'b11) ? 2 : (c[7:6] != 2'b00)));
         wr(CTRL_ADDR, c | 8'h0c);
         rd(CTRL_ADDR, c | 8'h08);
         wait_mode <= 1'b1;
         idle(2);
         check({15'h0, pump_on}, 16'h0000);
         rd(CTRL_ADDR, c | 8'h08);
         wait_mode <= 1'b0;
         stop_mode <= 1'b1;
         idle(2);
         check({pump_on, array_standby}, 16'h0000);
         rd(CTRL_ADDR, c | 8'h08);
         stop_mode <= 1'b0;
      end
      wr(CTRL_ADDR, 8'h00);
      override_high_voltage <= 1'b0;
      idle(5);
   endtask : op

   // cut a hang short
   initial
   begin
      repeat (100000) @(posedge sys_clk);
      num_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      tally_and_finish();
   end

   // main sequence
   initial
   begin
      logic [15:0] wa[10];
      logic [9:0] mapped;
      logic [7:0] r;
      rst = 1'b1;
      bus_addr = 16'h0000;
      bus_wdata = 8'h00;
      bus_write = 1'b0;
      bus_read = 1'b0;
      range_lock_byte = 8'h00;
      array_rdata = 8'h00;
      override_high_voltage = 1'b0;
      wait_mode = 1'b0;
      stop_mode = 1'b0;
      rd_seen = 1'b0;
      void'($urandom(32'hd683));
      wa = '{16'h0450, 16'h04ff, 16'h0500, 16'h0580, 16'h05ff, 16'h0600, 16'h0e00, 16'h7fff, 16'h8000, 16'hfe12};
      mapped = 10'b1101101100;
      idle(20);
      rst <= 1'b0;
      @(posedge sys_clk);
      check({program_select, erase_select, high_voltage_on, margin_read, erase_size, pump_on, pump_tick,
         array_standby}, 16'h0000);
      rd(CTRL_ADDR, 8'h00);
      // user windows pass array data, holes read zero
      for (int i = 0; i < 10; i++)
      begin
         r = $urandom;
         array_rdata <= r;
         rd(wa[i], mapped[9 - i] ? r : 8'h00);
      end
      // divider and block-size fields read back as written
      for (int i = 0; i < 16; i++)
      begin
         wr(CTRL_ADDR, 8'(i << 4));
         rd(CTRL_ADDR, 8'(i << 4));
      end
      // program and erase never both set
      wr(CTRL_ADDR, 8'h01);
      wr(CTRL_ADDR, 8'h03);
      rd(CTRL_ADDR, 8'h01);
      wr(CTRL_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'h03);
      rd(CTRL_ADDR, 8'h00);
      // high voltage refused without mode, then without the lock read
      wr(CTRL_ADDR, 8'h08);
      rd(CTRL_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'h01);
      wr(CTRL_ADDR, 8'h09);
      rd(CTRL_ADDR, 8'h01);
      wr(CTRL_ADDR, 8'h05);
      rd(CTRL_ADDR, 8'h05);
      wr(CTRL_ADDR, 8'h00);
      // stop in read mode enters standby
      stop_mode <= 1'b1;
      idle(2);
      check({15'h0, array_standby}, 16'h0001);
      stop_mode <= 1'b0;
      idle(2);
      check({15'h0, array_standby}, 16'h0000);
      // program cases per lock pattern, then erase sizes, then override
      op(4'h0, 16'h7ff8, 8'h01, 1'b0);
      op(4'h2, 16'h0ff8, 8'h41, 1'b0);
      op(4'h2, 16'h1000, 8'h01, 1'b0);
      op(4'h4, 16'h1ff8, 8'h81, 1'b0);
      op(4'h4, 16'h2000, 8'h01, 1'b0);
      op(4'h8, 16'h3ff8, 8'hc1, 1'b0);
      op(4'h8, 16'h4000, 8'h01, 1'b0);
      op(4'h6, 16'h0ff8, 8'h01, 1'b0);
      op(4'h6, 16'h1000, 8'h01, 1'b0);
      op(4'h1, 16'h0450, 8'h01, 1'b0);
      op(4'h2, 16'h0fc0, 8'h32, 1'b0);
      op(4'h2, 16'h0e00, 8'h22, 1'b0);
      op(4'h2, 16'h0e00, 8'h12, 1'b0);
      op(4'h0, 16'h0e00, 8'h02, 1'b0);
      op(4'h8, 16'h0450, 8'h02, 1'b0);
      op(4'hf, 16'h4000, 8'h01, 1'b1);
      // a second reset in mid-run clears every field
      wr(CTRL_ADDR, 8'hf1);
      // stop entered in program mode keeps the mode and is left through reset
      stop_mode <= 1'b1;
      idle(2);
      check({program_select, array_standby}, 16'h0002);
      rst <= 1'b1;
      stop_mode <= 1'b0;
      idle(3);
      rst <= 1'b0;
      rd(CTRL_ADDR, 8'h00);
      idle(3);
      tally_and_finish();
   end

endmodule : flash_program_erase_control_tb
